//--- rtl/prxc_pkg.sv
// package: register map, field positions, reset values and timing for the rx error counter / pcs config block
package prxc_pkg;
   localparam logic [7:0] FALSE_CARRIER_OFFS = 8'h14;
   localparam logic [7:0] RX_ERROR_OFFS = 8'h18;
   localparam logic [7:0] PCS_CONFIG_OFFS = 8'h16;
   localparam logic [7:0] LINK_STATUS_OFFS = 8'h1c;
   // the bus address of a register is four times its index
   localparam logic [7:0] FALSE_CARRIER_ADDR = {FALSE_CARRIER_OFFS[5:0], 2'b00};
   localparam logic [7:0] RX_ERROR_ADDR = {RX_ERROR_OFFS[5:0], 2'b00};
   localparam logic [7:0] PCS_CONFIG_ADDR = {PCS_CONFIG_OFFS[5:0], 2'b00};
   localparam logic [7:0] LINK_STATUS_ADDR = {LINK_STATUS_OFFS[5:0], 2'b00};
   localparam int FREE_CLK_BIT = 11;
   localparam int QUIET_TX_BIT = 10;
   localparam int FORCE_SD_BIT = 9;
   localparam int LINK_OPT_BIT = 8;
   localparam int DESCRAMBLER_TIMEOUT_SELECT_BIT = 7;
   localparam logic [15:0] PCS_CONFIG_RESET = 16'h0100;
   localparam logic [15:0] PCS_CONFIG_WMASK = 16'h0f80;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam int CLK_MHZ = 250;
   localparam int DESC_LONG_US = 2000;
   localparam int DESC_SHORT_NS = 722000;
   localparam int DESC_LONG_CYC = DESC_LONG_US * CLK_MHZ;
   localparam int DESC_SHORT_CYC = (DESC_SHORT_NS * CLK_MHZ) / 1000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : prxc_pkg

//--- rtl/prxc_sat_counter.sv
// saturating 8-bit event counter with clear-on-read
`timescale 1ns/1ps
module prxc_sat_counter (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic countEvent,
   input wire logic clearRead,
   output logic [7:0] count_q
);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_q <= prxc_pkg::COUNT_RESET;
      end else if (clearRead) begin
         // an event on the clearing read lands in the fresh count
         count_q <= countEvent ? 8'h01 : prxc_pkg::COUNT_RESET;
      end else if (countEvent && count_q != prxc_pkg::COUNT_MAX) begin
         count_q <= count_q + 8'h01;
      end
   end
endmodule : prxc_sat_counter

//--- rtl/prxc_regs.sv
// top: rx diagnostic counters and 100 Mb/s pcs configuration behind an axi4-lite slave
// Function
// - each false carrier event adds one to the 8-bit false carrier count
// - false carrier count sticks at ff instead of wrapping
// - counter register bits 15:8 read zero, writes to them are dropped
// - symbol error during valid carrier increments the receive error count
// - receive error count advances at most once per carrier event
// - no receive error count for a carrier event that saw a collision
// - receive error count sticks at its maximum
// - bit 11 selects free-running rx clock or alignment phase adjust
// - bit 10 enables true quiet transmit mode
// - bit 9 forces signal detect asserted in the pma
// - bit 8 set: link on signal plus lock, kept while signal valid
// - bit 8 clear: link kept only while signal valid and descrambler locked
// - bit 7 selects 2 ms or 722 us descrambler timeout
`timescale 1ns/1ps
module prxc_regs #(
   parameter int DescLongCycles = prxc_pkg::DESC_LONG_CYC,
   parameter int DescShortCycles = prxc_pkg::DESC_SHORT_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic falseCarrierPin,
   input wire logic carrierPin,
   input wire logic symbolErrorPin,
   input wire logic collisionPin,
   input wire logic signalValidPin,
   input wire logic descramblerLockPin,
   output logic rxClkFreeRun_q,
   output logic quietTransmit_q,
   output logic signalDetect_q,
   output logic linkUp_q,
   output logic descramblerTimeout_q
);
   // status inputs come from the pcs on another clock: two flops each
   // a level must stand one clock period to be sure of being seen
   localparam int NumIn = 6;
   logic [NumIn-1:0] syncA_q;
   logic [NumIn-1:0] syncB_q;
   logic [NumIn-1:0] rawIn;
   assign rawIn = {descramblerLockPin, signalValidPin, collisionPin, symbolErrorPin, carrierPin, falseCarrierPin};

   genvar gi;
   generate
      for (gi = 0; gi < NumIn; gi++) begin : g_sync
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               syncA_q[gi] <= 1'b0;
               syncB_q[gi] <= 1'b0;
            end else begin
               syncA_q[gi] <= rawIn[gi];
               syncB_q[gi] <= syncA_q[gi];
            end
         end
      end
   endgenerate

   logic falseCarrier, carrier, symbolError, collision, signalValid, descLock;
   assign falseCarrier = syncB_q[0];
   assign carrier = syncB_q[1];
   assign symbolError = syncB_q[2];
   assign collision = syncB_q[3];
   assign signalValid = syncB_q[4];
   assign descLock = syncB_q[5];

   logic falseCarrierPrev_q;
   logic carrierPrev_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         falseCarrierPrev_q <= 1'b0;
         carrierPrev_q <= 1'b0;
      end else begin
         falseCarrierPrev_q <= falseCarrier;
         carrierPrev_q <= carrier;
      end
   end

   logic falseCarrierEvent;
   assign falseCarrierEvent = falseCarrier && !falseCarrierPrev_q;

   // per carrier event: remember an error and a collision, decide at carrier end
   logic sawError_q;
   logic sawCollision_q;
   logic carrierEnd;
   logic rxErrorEvent;
   assign carrierEnd = carrierPrev_q && !carrier;
   // counting at carrier end is what makes one event count once
   assign rxErrorEvent = carrierEnd && sawError_q && !sawCollision_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sawError_q <= 1'b0;
         sawCollision_q <= 1'b0;
      end else if (carrier && !carrierPrev_q) begin
         sawError_q <= symbolError;
         sawCollision_q <= collision;
      end else if (carrier) begin
         sawError_q <= sawError_q || symbolError;
         sawCollision_q <= sawCollision_q || collision;
      end else begin
         sawError_q <= 1'b0;
         sawCollision_q <= 1'b0;
      end
   end

   // axi4-lite read side
   logic [7:0] falseCount;
   logic [7:0] rxErrCount;
   logic [15:0] pcsConfig_q;
   logic readFalse;
   logic readRxErr;
   logic arTake;
   // byte address on the bus is four times the register index
   logic rdSelFalse;
   logic rdSelRxErr;
   logic rdSelConfig;
   logic rdSelLink;
   assign rdSelFalse = s_axi_araddr == prxc_pkg::FALSE_CARRIER_ADDR;
   assign rdSelRxErr = s_axi_araddr == prxc_pkg::RX_ERROR_ADDR;
   assign rdSelConfig = s_axi_araddr == prxc_pkg::PCS_CONFIG_ADDR;
   assign rdSelLink = s_axi_araddr == prxc_pkg::LINK_STATUS_ADDR;
   assign arTake = s_axi_arvalid && s_axi_arready;
   assign readFalse = arTake && rdSelFalse;
   assign readRxErr = arTake && rdSelRxErr;

   prxc_sat_counter u_false_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .countEvent(falseCarrierEvent),
      .clearRead(readFalse),
      .count_q(falseCount)
   );

   prxc_sat_counter u_rxerr_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .countEvent(rxErrorEvent),
      .clearRead(readRxErr),
      .count_q(rxErrCount)
   );

   // word and response of the addressed register, unmapped gives an error
   logic [31:0] rdWord;
   logic [1:0] rdResp;
   always_comb begin
      rdWord = 32'h00000000;
      rdResp = prxc_pkg::RESP_OKAY;
      if (rdSelFalse) begin
         rdWord = {24'h000000, falseCount};
      end else if (rdSelRxErr) begin
         rdWord = {24'h000000, rxErrCount};
      end else if (rdSelConfig) begin
         rdWord = {16'h0000, pcsConfig_q};
      end else if (rdSelLink) begin
         rdWord = {29'h0, descLock, signalValid, linkUp_q};
      end else begin
         rdResp = prxc_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end else if (arTake) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // read data only moves on a take, so it stands while rvalid waits for rready
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= prxc_pkg::RESP_OKAY;
      end else if (arTake) begin
         s_axi_rdata <= rdWord;
         s_axi_rresp <= rdResp;
      end
   end

   // axi4-lite write side: address and data latched in either order
   logic haveAddr_q;
   logic haveData_q;
   logic [7:0] wAddr_q;
   logic [15:0] wData_q;
   logic [1:0] wStrb_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         haveAddr_q <= 1'b0;
         haveData_q <= 1'b0;
         wAddr_q <= 8'h00;
         wData_q <= 16'h0000;
         wStrb_q <= 2'b00;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else if (haveAddr_q && haveData_q) begin
         haveAddr_q <= 1'b0;
         haveData_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            haveAddr_q <= 1'b1;
            wAddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            haveData_q <= 1'b1;
            wData_q <= s_axi_wdata[15:0];
            wStrb_q <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   logic doWrite;
   assign doWrite = haveAddr_q && haveData_q;

   // write decode: counters and status accept a write and drop it
   logic wrSelFalse;
   logic wrSelRxErr;
   logic wrSelConfig;
   logic wrSelLink;
   logic wrMapped;
   logic cfgWrite;
   assign wrSelFalse = wAddr_q == prxc_pkg::FALSE_CARRIER_ADDR;
   assign wrSelRxErr = wAddr_q == prxc_pkg::RX_ERROR_ADDR;
   assign wrSelConfig = wAddr_q == prxc_pkg::PCS_CONFIG_ADDR;
   assign wrSelLink = wAddr_q == prxc_pkg::LINK_STATUS_ADDR;
   assign wrMapped = wrSelFalse || wrSelRxErr || wrSelConfig || wrSelLink;
   assign cfgWrite = doWrite && wrSelConfig;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= prxc_pkg::RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         // counters are read-only: writes are accepted and dropped
         if (wrMapped) begin
            s_axi_bresp <= prxc_pkg::RESP_OKAY;
         end else begin
            s_axi_bresp <= prxc_pkg::RESP_SLVERR;
         end
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // config: bits 15:12 must be written zero by software; they are stored as written
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pcsConfig_q <= prxc_pkg::PCS_CONFIG_RESET;
      end else if (cfgWrite) begin
         if (wStrb_q[0]) begin
            pcsConfig_q[7] <= wData_q[7];
         end
         if (wStrb_q[1]) begin
            pcsConfig_q[15:8] <= wData_q[15:8];
         end
      end
   end

   // pcs controls, each straight from a flop
   logic linkOpt;
   assign linkOpt = pcsConfig_q[prxc_pkg::LINK_OPT_BIT];
   logic effSignal;
   assign effSignal = signalValid || pcsConfig_q[prxc_pkg::FORCE_SD_BIT];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxClkFreeRun_q <= 1'b0;
         quietTransmit_q <= 1'b0;
         signalDetect_q <= 1'b0;
      end else begin
         rxClkFreeRun_q <= pcsConfig_q[prxc_pkg::FREE_CLK_BIT];
         quietTransmit_q <= pcsConfig_q[prxc_pkg::QUIET_TX_BIT];
         signalDetect_q <= effSignal;
      end
   end

   // link maintenance
   // a lost condition drops link on the next edge; there is no glitch filter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         linkUp_q <= 1'b0;
      end else if (!linkUp_q) begin
         linkUp_q <= effSignal && descLock;
      end else if (linkOpt) begin
         linkUp_q <= effSignal;
      end else begin
         linkUp_q <= effSignal && descLock;
      end
   end

   // descrambler timeout: reloads while locked or without signal, counts down to zero while unlocked with signal
   // 32 bits leave ample room for the long timeout at this clock
   logic [31:0] descTimer_q;
   logic [31:0] descReload;
   assign descReload = pcsConfig_q[prxc_pkg::DESCRAMBLER_TIMEOUT_SELECT_BIT] ? 32'(DescLongCycles) : 32'(DescShortCycles);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         descTimer_q <= 32'(DescShortCycles);
      end else if (descLock || !effSignal) begin
         descTimer_q <= descReload;
      end else if (descTimer_q != 32'd0) begin
         descTimer_q <= descTimer_q - 32'd1;
      end
   end

   // the flag stands while unlocked with a signal present and the timer spent
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         descramblerTimeout_q <= 1'b0;
      end else begin
         descramblerTimeout_q <= descTimer_q == 32'd0 && !descLock && effSignal;
      end
   end
endmodule : prxc_regs

//--- testbench/prxc_regs_asserts.sv
// port checker for the rx counter and pcs config block
`timescale 1ns/1ps
module prxc_regs_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic signalValidPin,
   input wire logic descramblerLockPin,
   input wire logic signalDetect_q,
   input wire logic linkUp_q,
   input wire logic descramblerTimeout_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
   rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r dropped");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
   read_lat_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready)) else $error("r early");
   sig_det_a: assert property (signalValidPin [*5] |-> signalDetect_q) else $error("no detect");
   link_lock_a: assert property (!descramblerLockPin [*6] |-> !$rose(linkUp_q)) else $error("link no lock");
   tmo_locked_a: assert property (descramblerLockPin [*5] |-> !descramblerTimeout_q) else $error("tmo locked");
   tmo_nosig_a: assert property (!signalDetect_q |-> !descramblerTimeout_q) else $error("tmo no sig");
endmodule : prxc_regs_asserts

bind prxc_regs prxc_regs_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .signalValidPin(signalValidPin),
   .descramblerLockPin(descramblerLockPin), .signalDetect_q(signalDetect_q), .linkUp_q(linkUp_q),
   .descramblerTimeout_q(descramblerTimeout_q));

//--- testbench/prxc_mgmt_model.sv
// management master model on the axi4-lite register port
`timescale 1ns/1ps
module prxc_mgmt_model (
   input wire logic clk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= {20'h0, v[11:0]};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // aw and w may be taken on different edges
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid && !awready || wvalid && !wready);
      wdata <= ~wdata;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      do @(posedge clk); while (!rvalid);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : prxc_mgmt_model

//--- testbench/prxc_regs_tb_top.sv
// self-checking bench for the rx counters and pcs config block
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module prxc_regs_tb_top;
   localparam logic [7:0] FC = prxc_pkg::FALSE_CARRIER_ADDR;
   localparam logic [7:0] RE = prxc_pkg::RX_ERROR_ADDR;
   localparam logic [7:0] CF = prxc_pkg::PCS_CONFIG_ADDR;
   localparam logic [7:0] LS = prxc_pkg::LINK_STATUS_ADDR;
   logic clk = 0;
   logic sys_rst = 1;
   logic [5:0] pins = '0;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic rxFree, quietTx, sigDet, link, descTo;
   logic [15:0] c;
   int failures = 0, n_checks = 0, cyc = 0, n;
   initial forever #2 clk = ~clk;
   // short timer values keep the timeout cases within a few dozen cycles
   prxc_regs #(.DescLongCycles(20), .DescShortCycles(10)) DUT (.clk(clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .falseCarrierPin(pins[0]), .carrierPin(pins[1]), .symbolErrorPin(pins[2]),
      .collisionPin(pins[3]), .signalValidPin(pins[4]), .descramblerLockPin(pins[5]),
      .rxClkFreeRun_q(rxFree), .quietTransmit_q(quietTx), .signalDetect_q(sigDet), .linkUp_q(link),
      .descramblerTimeout_q(descTo));
   prxc_mgmt_model u_mgmt (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));
   function automatic logic [15:0] sat(input int k);
      return (k > 255) ? 16'h00ff : 16'(k);
   endfunction : sat
   task automatic tally_and_finish();
      if (failures == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic setp(input int i, input logic v, input int h);
      @(posedge clk);
      pins[i] <= v;
      repeat (h) @(posedge clk);
   endtask : setp
   task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string s);
      u_mgmt.rd(a, d, r);
      `CHK(s, {16'h0, e}, d)
   endtask : rdc
   task automatic wrc(input logic [15:0] v);
      u_mgmt.wr(CF, v, r);
      repeat (4) @(posedge clk);
   endtask : wrc
   task automatic ev(input logic err, input logic col);
      setp(1, 1, 2);
      if (col) setp(3, 1, 2);
      if (err) repeat (2) begin
         setp(2, 1, 1);
         setp(2, 0, 1);
      end
      setp(1, 0, 2);
      setp(3, 0, 4);
   endtask : ev
   initial begin
      void'($urandom(77));
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(CF, prxc_pkg::PCS_CONFIG_RESET, "cfg reset");
      rdc(FC, 16'h0, "fc reset");
      for (int i = 0; i < 6; i++) begin
         c = (i == 0) ? 16'h0f80 : (i == 1) ? 16'h0 : 16'($urandom) & 16'h0f80;
         wrc(c);
         rdc(CF, c, "cfg");
         `CHK("free clk", c[11], rxFree)
         `CHK("quiet tx", c[10], quietTx)
         `CHK("sig det", c[9], sigDet)
      end
      n = 1 + $urandom_range(20);
      repeat (n) begin
         setp(0, 1, 1);
         setp(0, 0, 1);
      end
      repeat (4) @(posedge clk);
      u_mgmt.wr(FC, 16'hffff, r);
      `CHK("fc wr resp", prxc_pkg::RESP_OKAY, r)
      rdc(FC, sat(n), "fc count");
      rdc(FC, 16'h0, "fc cleared");
      repeat (260) begin
         setp(0, 1, 1);
         setp(0, 0, 1);
      end
      repeat (4) @(posedge clk);
      rdc(FC, sat(260), "fc sat");
      ev(1, 0);
      ev(1, 0);
      ev(0, 0);
      ev(1, 1);
      rdc(RE, 16'h2, "re count");
      repeat (256) ev(1, 0);
      rdc(RE, sat(256), "re sat");
      wrc(16'h0100);
      setp(4, 1, 2);
      setp(5, 1, 6);
      `CHK("link up", 1'b1, link)
      setp(5, 0, 16);
      `CHK("link kept", 1'b1, link)
      `CHK("short tmo", 1'b1, descTo)
      wrc(16'h0000);
      setp(5, 1, 6);
      setp(5, 0, 6);
      `CHK("link lost", 1'b0, link)
      wrc(16'h0080);
      setp(5, 1, 6);
      setp(5, 0, 16);
      `CHK("long tmo wait", 1'b0, descTo)
      repeat (10) @(posedge clk);
      `CHK("long tmo", 1'b1, descTo)
      rdc(LS, 16'h0002, "link status");
      u_mgmt.rd(8'h20, d, r);
      `CHK("unmapped", {prxc_pkg::RESP_SLVERR, 32'h0}, {r, d})
      tally_and_finish();
   end
endmodule : prxc_regs_tb_top
